// File: pkg/ebi_pkg.sv
/*
 * shared constants and types for the external bus and interrupt pin block.
 * assumes one 40 MHz clock and pins resolved by the testbench from the enables.
 */
`default_nettype none

package ebi_pkg;

    localparam int ADDR_W = 23;
    localparam int LOW_W  = 16;
    localparam int DATA_W = 16;
    localparam int IRQ_N  = 4;

    localparam logic [22:0] ADDR_RST  = 23'h00_0000;
    localparam logic [15:0] DATA_RST  = 16'h0000;
    localparam logic [3:0]  IRQ_NONE  = 4'h0;
    localparam logic [3:0]  IRQ_ONE   = 4'h1;
    localparam logic [6:0]  UPPER_OFF = 7'h00;
    // vector table base and spacing are free choices
    localparam logic [15:0] VEC_BASE  = 16'h00C0;
    localparam int          VEC_SHIFT = 2;
    // last count of the three-cycle address hold: pin settle plus two sync stages on the return data
    localparam logic [1:0]  ACC_LAST  = 2'h2;
    localparam logic [1:0]  CNT_RST   = 2'h0;
    localparam logic [1:0]  CNT_ONE   = 2'h1;

    typedef enum logic [1:0]
    {
        EBI_SP_PROG = 2'h0,
        EBI_SP_DATA = 2'h1,
        EBI_SP_IO   = 2'h2
    } ebi_space_t;

    typedef enum logic [1:0]
    {
        EBI_IDLE = 2'h0,
        EBI_ACC  = 2'h1,
        EBI_REL  = 2'h3
    } ebi_state_t;

    typedef struct packed
    {
        ebi_space_t  space;
        logic        write;
        logic [22:0] addr;
        logic [15:0] wdata;
    } ebi_req_t;

endpackage

`default_nettype wire

// File: rtl/ebi_bus_irq.sv
/*
 * external parallel bus pins (address, data with keepers, vector fetch
 * acknowledge) and the four maskable external interrupt inputs.
 * assumes the core issues one access at a time and the testbench
 * resolves each pin from its output, enable and keeper drive.
 */
// Contract
// [RULE1] drive a 23-line address bus, line 22 most significant.
// [RULE2] low sixteen address lines serve every external access.
// [RULE3] upper seven address lines only for program space, zero otherwise.
// [RULE4] float address lines in hold mode or while outputs-off is low.
// [RULE5] shared 16-bit bidirectional data bus, bit 15 most significant.
// [RULE6] float data unless writing, in reset, hold, or outputs-off low.
// [RULE7] enabled keepers hold each undriven data line at its last level.
// [RULE8] keepers off after reset, switched by the bank switch keeper bit.
// [RULE9] acknowledge low during vector fetch; floated while outputs-off is low.
// [RULE10] four interrupts, fixed priority, masked per bit and globally.
// [RULE11] requests latch in flags that software polls and clears.
// [RULE12] external master requests hold; on acknowledge lines are floated.
// [RULE13] synchronise each interrupt input before setting its flag.
`timescale 1ns/1ps
`default_nettype none

module ebi_bus_irq
(
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             reset,
    // core access port
    input  wire logic             req_valid,
    input  wire ebi_pkg::ebi_req_t req,
    output var  logic             req_ready,
    output var  logic             rsp_valid,
    output var  logic [15:0]      rsp_rdata,
    // interrupt control
    input  wire logic             global_irq_disable,
    input  wire logic             irq_mask_wr,
    input  wire logic [3:0]       irq_mask_wdata,
    input  wire logic [3:0]       irq_flag_clear,
    output var  logic [3:0]       irq_mask_register,
    output var  logic [3:0]       irq_flags,
    output var  logic             irq_taken,
    output var  logic [1:0]       irq_taken_num,
    // bank switch keeper control
    input  wire logic             bank_switch_wr,
    input  wire logic             data_keeper_enable_wdata,
    output var  logic             data_keeper_enable,
    // pins
    input  wire logic             hold_req_n,
    output var  logic             hold_ack_n,
    input  wire logic             outputs_off_n,
    input  wire logic [3:0]       external_irq_lines_n,
    output var  logic [22:0]      ext_address_lines,
    output var  logic             ext_address_oe,
    input  wire logic [15:0]      ext_data_lines_i,
    output var  logic [15:0]      ext_data_lines_o,
    output var  logic             ext_data_lines_oe,
    output var  logic             data_keeper_drive,
    output var  logic             interrupt_acknowledge_n,
    output var  logic             interrupt_acknowledge_oe
);

    function automatic logic [1:0] pick_irq(input logic [3:0] en);
        logic [1:0] idx;
        idx = 2'h0;
        for (int i = ebi_pkg::IRQ_N - 1; i >= 0; i--)
        begin
            if (en[i])
            begin
                idx = 2'(i);
            end
        end
        return idx;
    endfunction

    function automatic logic [22:0] bus_addr(input ebi_pkg::ebi_req_t r);
        if (r.space == ebi_pkg::EBI_SP_PROG)
        begin
            return r.addr;
        end
        return {ebi_pkg::UPPER_OFF, r.addr[15:0]};
    endfunction

    // pin synchronisers; stage one is read only by stage two
    logic [1:0]  hold_m_r, off_m_r;
    logic [3:0]  irq_m_r, irq_s_r, irq_d_r;
    logic [15:0] dat_m_r, dat_s_r;
    logic        hold_s, off_s;

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            hold_m_r <= 2'h3;
            off_m_r  <= 2'h3;
            irq_m_r  <= 4'hF;
            irq_s_r  <= 4'hF;
            irq_d_r  <= 4'hF;
            dat_m_r  <= ebi_pkg::DATA_RST;
            dat_s_r  <= ebi_pkg::DATA_RST;
        end
        else
        begin
            hold_m_r <= {hold_m_r[0], hold_req_n};
            off_m_r  <= {off_m_r[0], outputs_off_n};
            irq_m_r  <= external_irq_lines_n;  // RULE13
            irq_s_r  <= irq_m_r;
            irq_d_r  <= irq_s_r;
            dat_m_r  <= ext_data_lines_i;
            dat_s_r  <= dat_m_r;
        end
    end

    assign hold_s = ~hold_m_r[1];
    assign off_s  = off_m_r[1];

    // interrupt flags, mask and priority pick
    logic [3:0] flags_nxt, mask_nxt, irq_fall, irq_en, taken_mask;
    logic [1:0] irq_sel;
    logic       go_irq, go_req;

    assign irq_fall = irq_d_r & ~irq_s_r;
    assign irq_en   = irq_flags & irq_mask_register & {4{~global_irq_disable}};  // RULE10
    assign irq_sel  = pick_irq(irq_en);  // RULE10

    always_comb
    begin
        mask_nxt = irq_mask_wr ? irq_mask_wdata : irq_mask_register;
        // a new edge wins over a software clear or an acceptance
        flags_nxt = (irq_flags & ~irq_flag_clear & ~taken_mask) | irq_fall;  // RULE11
    end

    // access sequencer
    ebi_pkg::ebi_state_t state_r, state_nxt;
    logic [1:0]  cnt_r, cnt_nxt;
    logic        wr_r, wr_nxt, vec_r, vec_nxt, upper_r, upper_nxt;
    logic [15:0] wdata_r, wdata_nxt, keep_nxt;
    logic [22:0] addr_nxt;
    logic        ready_nxt, rsp_nxt, hack_nxt, aoe_nxt, doe_nxt, ack_nxt;
    logic        bus_free;

    assign bus_free   = off_s && !hold_s && hold_ack_n;
    assign go_req     = (state_r == ebi_pkg::EBI_IDLE) && req_valid && req_ready;
    assign go_irq     = (state_r == ebi_pkg::EBI_IDLE) && bus_free && (irq_en != ebi_pkg::IRQ_NONE) && !go_req;
    assign taken_mask = go_irq ? (ebi_pkg::IRQ_ONE << irq_sel) : ebi_pkg::IRQ_NONE;

    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        wr_nxt    = wr_r;
        vec_nxt   = vec_r;
        upper_nxt = upper_r;
        wdata_nxt = wdata_r;
        addr_nxt  = ext_address_lines;
        rsp_nxt   = 1'b0;
        case (state_r)
            ebi_pkg::EBI_IDLE:
            begin
                cnt_nxt = ebi_pkg::CNT_RST;
                if (go_req)
                begin
                    state_nxt = ebi_pkg::EBI_ACC;
                    wr_nxt    = req.write;
                    vec_nxt   = 1'b0;
                    upper_nxt = (req.space == ebi_pkg::EBI_SP_PROG);
                    wdata_nxt = req.wdata;  // RULE5
                    addr_nxt  = bus_addr(req);  // RULE1 RULE2 RULE3
                end
                else if (go_irq)
                begin
                    state_nxt = ebi_pkg::EBI_ACC;
                    wr_nxt    = 1'b0;
                    vec_nxt   = 1'b1;
                    upper_nxt = 1'b0;
                    // vector location on the low lines only
                    addr_nxt  = {ebi_pkg::UPPER_OFF,
                                 ebi_pkg::VEC_BASE + (16'(irq_sel) << ebi_pkg::VEC_SHIFT)};  // RULE9
                end
            end
            ebi_pkg::EBI_ACC:
            begin
                cnt_nxt = cnt_r + ebi_pkg::CNT_ONE;
                if (cnt_r == ebi_pkg::ACC_LAST)
                begin
                    state_nxt = ebi_pkg::EBI_REL;
                    rsp_nxt   = !vec_r;
                end
            end
            ebi_pkg::EBI_REL:
            begin
                // turnaround cycle so a read never meets the next write on the wire
                state_nxt = ebi_pkg::EBI_IDLE;
            end
            default:
            begin
                state_nxt = ebi_pkg::EBI_IDLE;
            end
        endcase
        // hold is granted only between accesses
        hack_nxt  = !(hold_s && (state_nxt == ebi_pkg::EBI_IDLE));  // RULE12
        aoe_nxt   = off_s && hack_nxt;  // RULE4
        doe_nxt   = (state_nxt == ebi_pkg::EBI_ACC) && wr_nxt && off_s && hack_nxt;  // RULE6
        ack_nxt   = !((state_nxt == ebi_pkg::EBI_ACC) && vec_nxt);  // RULE9
        ready_nxt = (state_nxt == ebi_pkg::EBI_IDLE) && bus_free && hack_nxt;
        keep_nxt  = doe_nxt ? wdata_nxt : (ext_data_lines_oe ? ext_data_lines_o : dat_s_r);  // RULE7
    end

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            state_r                  <= ebi_pkg::EBI_IDLE;
            cnt_r                    <= ebi_pkg::CNT_RST;
            wr_r                     <= 1'b0;
            vec_r                    <= 1'b0;
            upper_r                  <= 1'b0;
            wdata_r                  <= ebi_pkg::DATA_RST;
            req_ready                <= 1'b0;
            rsp_valid                <= 1'b0;
            rsp_rdata                <= ebi_pkg::DATA_RST;
            irq_mask_register        <= ebi_pkg::IRQ_NONE;
            irq_flags                <= ebi_pkg::IRQ_NONE;
            irq_taken                <= 1'b0;
            irq_taken_num            <= 2'h0;
            data_keeper_enable       <= 1'b0;  // RULE8
            hold_ack_n               <= 1'b1;
            ext_address_lines        <= ebi_pkg::ADDR_RST;
            ext_address_oe           <= 1'b0;
            ext_data_lines_o         <= ebi_pkg::DATA_RST;
            ext_data_lines_oe        <= 1'b0;  // RULE6
            data_keeper_drive        <= 1'b0;
            interrupt_acknowledge_n  <= 1'b1;
            interrupt_acknowledge_oe <= 1'b0;
        end
        else
        begin
            state_r                  <= state_nxt;
            cnt_r                    <= cnt_nxt;
            wr_r                     <= wr_nxt;
            vec_r                    <= vec_nxt;
            upper_r                  <= upper_nxt;
            wdata_r                  <= wdata_nxt;
            req_ready                <= ready_nxt;
            rsp_valid                <= rsp_nxt;
            rsp_rdata                <= rsp_nxt ? dat_s_r : rsp_rdata;
            irq_mask_register        <= mask_nxt;
            irq_flags                <= flags_nxt;
            irq_taken                <= go_irq;
            irq_taken_num            <= go_irq ? irq_sel : irq_taken_num;
            data_keeper_enable       <= bank_switch_wr ? data_keeper_enable_wdata : data_keeper_enable;  // RULE8
            hold_ack_n               <= hack_nxt;
            ext_address_lines        <= addr_nxt;
            ext_address_oe           <= aoe_nxt;
            ext_data_lines_o         <= keep_nxt;
            ext_data_lines_oe        <= doe_nxt;
            data_keeper_drive        <= data_keeper_enable && !doe_nxt;  // RULE7
            interrupt_acknowledge_n  <= ack_nxt;
            interrupt_acknowledge_oe <= off_s;  // RULE9
        end
    end

    // checks
    a_low_addr_match: assert property (@(posedge ref_clk) disable iff (reset)
        go_req |=> ext_address_lines[15:0] == $past(req.addr[15:0]))  // RULE2
        else $error("low address lines do not carry the request address");
    a_prog_full_addr: assert property (@(posedge ref_clk) disable iff (reset)
        (state_r == ebi_pkg::EBI_ACC && upper_r) |-> ##0 $stable(ext_address_lines) or cnt_r == ebi_pkg::CNT_RST)  // RULE1
        else $error("program address moved during an access");
    a_upper_zero: assert property (@(posedge ref_clk) disable iff (reset)
        (state_r == ebi_pkg::EBI_ACC && !upper_r) |-> ext_address_lines[22:16] == ebi_pkg::UPPER_OFF)  // RULE3
        else $error("upper address lines used outside program space");
    a_hold_float: assert property (@(posedge ref_clk) disable iff (reset)
        !hold_ack_n |-> !ext_address_oe && !ext_data_lines_oe)  // RULE4 RULE12
        else $error("lines driven while hold is acknowledged");
    a_off_float: assert property (@(posedge ref_clk) disable iff (reset)
        !off_s |=> !ext_address_oe && !ext_data_lines_oe && !interrupt_acknowledge_oe)  // RULE4 RULE9
        else $error("pins driven while outputs are off");
    a_write_only_drive: assert property (@(posedge ref_clk) disable iff (reset)
        ext_data_lines_oe |-> state_r == ebi_pkg::EBI_ACC && wr_r && ext_data_lines_o == wdata_r)  // RULE5 RULE6
        else $error("data bus driven outside a write");
    a_keeper_level: assert property (@(posedge ref_clk) disable iff (reset)
        (data_keeper_drive && $past(ext_data_lines_oe)) |-> ext_data_lines_o == $past(ext_data_lines_o))  // RULE7
        else $error("keeper lost the last driven level");
    a_keeper_steer: assert property (@(posedge ref_clk) disable iff (reset)
        !bank_switch_wr |=> $stable(data_keeper_enable))  // RULE8
        else $error("keeper enable changed without a write");
    a_interrupt_acknowledge_n_vector: assert property (@(posedge ref_clk) disable iff (reset)
        go_irq |=> !interrupt_acknowledge_n [*3] ##1 interrupt_acknowledge_n)  // RULE9
        else $error("acknowledge not held for the vector fetch");
    a_irq_enabled: assert property (@(posedge ref_clk) disable iff (reset)
        irq_taken |-> (($past(irq_en) >> irq_taken_num) & ebi_pkg::IRQ_ONE) != ebi_pkg::IRQ_NONE)  // RULE10
        else $error("masked interrupt was taken");
    a_irq_priority: assert property (@(posedge ref_clk) disable iff (reset)
        irq_taken |-> ($past(irq_en) & ((ebi_pkg::IRQ_ONE << irq_taken_num) - ebi_pkg::IRQ_ONE)) == ebi_pkg::IRQ_NONE)  // RULE10
        else $error("lower priority interrupt taken first");
    a_flag_latch: assert property (@(posedge ref_clk) disable iff (reset)
        (irq_fall != ebi_pkg::IRQ_NONE) |=> (irq_flags & $past(irq_fall)) == $past(irq_fall))  // RULE11 RULE13
        else $error("interrupt edge not latched");

    c_write: cover property (@(posedge ref_clk) disable iff (reset) go_req && req.write);
    c_read_done: cover property (@(posedge ref_clk) disable iff (reset) rsp_valid);
    c_vector: cover property (@(posedge ref_clk) disable iff (reset) irq_taken);
    c_hold: cover property (@(posedge ref_clk) disable iff (reset) !hold_ack_n);

endmodule // ebi_bus_irq

`default_nettype wire

// File: rtl/ebi_unused.sv
`timescale 1ns/1ps

// File: testbench/ebi_ext_mem.sv
/*
 * external memory model on the far side of the data bus; resolves the data pin.
 * assumes the bench enables it only while it may answer.
 */
`timescale 1ns/1ps
`default_nettype none
module ebi_ext_mem
(
    // clock and control
    input  wire logic        ref_clk,
    input  wire logic        mem_en,
    // design pins
    input  wire logic [22:0] addr,
    input  wire logic [15:0] dout,
    input  wire logic        doe,
    input  wire logic        keep,
    // resolved data pin
    output var  logic [15:0] pin
);
    logic [15:0] mem [256];
    logic [15:0] last;
    initial for (int i = 0; i < 256; i++) mem[i] = {8'hA5, 8'(i)};
    // an undriven line toggles, so a missing keeper cannot pass by luck
    always_comb pin = doe ? dout : mem_en ? mem[addr[7:0]] : keep ? dout : ~last;
    always @(posedge ref_clk)
    begin
        last <= pin;
        if (doe) mem[addr[7:0]] <= pin;
    end
endmodule // ebi_ext_mem
`default_nettype wire

// File: testbench/ebi_bus_irq_test.sv
/*
 * self-checking bench for the external bus and interrupt pin block.
 * assumes the memory model resolves the data pin.
 */
`timescale 1ns/1ps
`default_nettype none
module ebi_bus_irq_test;
    logic ref_clk = 0, reset = 1, req_valid = 0, gdis = 1, mwr = 0, bwr = 0, kwd = 0;
    logic hold_n = 1, off_n = 1, mem_en = 1;
    logic [3:0] mwd = 4'h0, fclr = 4'h0, irq_n = 4'hF;
    ebi_pkg::ebi_req_t req = '0;
    logic rdy, rv, tk, hack, aoe, doe, keep, ken, ia, iaoe;
    logic [15:0] rd, dout, pin;
    logic [3:0] msk, flg;
    logic [1:0] tnum;
    logic [22:0] addr;
    int bad_count = 0, check_count = 0, cyc = 0;

    ebi_bus_irq ebi_bus_irq_inst (.ref_clk(ref_clk), .reset(reset), .req_valid(req_valid), .req(req),
        .req_ready(rdy), .rsp_valid(rv), .rsp_rdata(rd), .global_irq_disable(gdis), .irq_mask_wr(mwr),
        .irq_mask_wdata(mwd), .irq_flag_clear(fclr), .irq_mask_register(msk), .irq_flags(flg),
        .irq_taken(tk), .irq_taken_num(tnum), .bank_switch_wr(bwr), .data_keeper_enable_wdata(kwd),
        .data_keeper_enable(ken), .hold_req_n(hold_n), .hold_ack_n(hack), .outputs_off_n(off_n),
        .external_irq_lines_n(irq_n), .ext_address_lines(addr), .ext_address_oe(aoe),
        .ext_data_lines_i(pin), .ext_data_lines_o(dout), .ext_data_lines_oe(doe),
        .data_keeper_drive(keep), .interrupt_acknowledge_n(ia), .interrupt_acknowledge_oe(iaoe));
    ebi_ext_mem ebi_ext_mem_inst (.ref_clk(ref_clk), .mem_en(mem_en), .addr(addr), .dout(dout),
        .doe(doe), .keep(keep), .pin(pin));

    initial forever #12.5 ref_clk = ~ref_clk;

    task automatic check_val(input string what, input logic [22:0] exp, input logic [22:0] got);
        check_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // one core access; pins checked in the first address cycle, answer three edges after the take
    task automatic access(input ebi_pkg::ebi_space_t sp, input logic wr, input logic [22:0] a,
                          input logic [15:0] wd, input logic [22:0] ea, input logic [15:0] erd);
        int n;
        n = 0;
        req = '{space: sp, write: wr, addr: a, wdata: wd};
        req_valid = 1;
        @(negedge ref_clk);
        while (rdy !== 1'b1 && n < 20)
        begin
            n++;
            @(negedge ref_clk);
        end
        @(posedge ref_clk);
        #1 req_valid = 0;
        @(negedge ref_clk);
        check_val("address", ea, addr);
        check_val("data drive", 23'(wr), 23'(doe));
        if (wr)
            check_val("write data", 23'(wd), 23'(dout));
        repeat (3) @(negedge ref_clk);
        check_val("response", 23'h1, 23'(rv));
        check_val("data released", 23'h0, 23'(doe));
        if (!wr)
            check_val("read data", 23'(erd), 23'(rd));
        tick(1);
    endtask

    // vec is the expected vector location, worked out by hand from the chosen table base and step
    task automatic wait_taken(input logic [1:0] idx, input logic [15:0] vec);
        int n;
        n = 0;
        @(negedge ref_clk);
        while (tk !== 1'b1 && n < 20)
        begin
            n++;
            @(negedge ref_clk);
        end
        check_val("taken", 23'h1, 23'(tk));
        check_val("taken index", 23'(idx), 23'(tnum));
        check_val("ack level", 23'h0, 23'(ia));
        check_val("vector", 23'(vec), 23'(addr[15:0]));
        tick(1);
    endtask

    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            bad_count++;
            end_of_test();
        end
    end

    initial
    begin
        tick(1);
        check_val("reset drive", 23'h0, 23'({doe, iaoe, ken}));
        tick(3);
        reset = 0;
        access(ebi_pkg::EBI_SP_PROG, 1, 23'h5A_1234, 16'hBEEF, 23'h5A_1234, 16'h0000);
        access(ebi_pkg::EBI_SP_PROG, 0, 23'h5A_1234, 16'h0000, 23'h5A_1234, 16'hBEEF);
        access(ebi_pkg::EBI_SP_DATA, 0, 23'h7F_AB33, 16'h0000, 23'h00_AB33, 16'hA533);
        access(ebi_pkg::EBI_SP_IO, 1, 23'h12_0044, 16'h1357, 23'h00_0044, 16'h0000);
        access(ebi_pkg::EBI_SP_IO, 0, 23'h12_0044, 16'h0000, 23'h00_0044, 16'h1357);
        // keepers: the bus is left undriven after a write
        kwd = 1;
        bwr = 1;
        tick(1);
        bwr = 0;
        access(ebi_pkg::EBI_SP_DATA, 1, 23'h00_0010, 16'h3C5A, 23'h00_0010, 16'h0000);
        mem_en = 0;
        tick(4);
        check_val("keeper", {6'h0, 1'b1, 16'h3C5A}, {6'h0, keep, pin});
        kwd = 0;
        bwr = 1;
        tick(1);
        bwr = 0;
        tick(2);
        check_val("keeper off", 23'h0, 23'({ken, keep}));
        mem_en = 1;
        // hold request from an outside master, then outputs-off low
        hold_n = 0;
        tick(6);
        check_val("hold float", 23'h0, 23'({hack, aoe, doe}));
        hold_n = 1;
        off_n = 0;
        tick(6);
        check_val("off float", 23'h0, 23'({aoe, doe, iaoe}));
        off_n = 1;
        tick(6);
        // interrupts: flag, poll, clear, mask, vector fetch
        mwd = 4'hF;
        mwr = 1;
        tick(1);
        mwr = 0;
        check_val("mask", 23'hF, 23'(msk));
        irq_n = 4'h8;
        tick(3);
        irq_n = 4'hF;
        tick(6);
        check_val("flags", 23'h7, 23'(flg));
        fclr = 4'h2;
        tick(1);
        fclr = 4'h0;
        tick(1);
        check_val("flags cleared", 23'h5, 23'(flg));
        mwd = 4'hE;
        mwr = 1;
        tick(1);
        mwr = 0;
        gdis = 0;
        wait_taken(2'h2, 16'h00C8);
        tick(10);
        check_val("masked pending", 23'h1, 23'(flg));
        mwd = 4'hF;
        mwr = 1;
        tick(1);
        mwr = 0;
        wait_taken(2'h0, 16'h00C0);
        // keeper comes back off after a second reset
        kwd = 1;
        bwr = 1;
        tick(1);
        bwr = 0;
        reset = 1;
        tick(2);
        reset = 0;
        tick(2);
        check_val("keeper reset", 23'h0, 23'(ken));
        end_of_test();
    end
endmodule // ebi_bus_irq_test
`default_nettype wire
